// ### hdl/fics_pkg.sv
// constants and types for the fast interrupt context swap unit
// assumes an 8-bit core with byte-wide special registers and a 16-bit program counter
package fics_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // register addresses of the service start pointer byte pair
   localparam logic [7:0] SSP_HI_ADDR = 8'hda; // high byte
   localparam logic [7:0] SSP_LO_ADDR = 8'hdb; // low byte
   // field positions inside the system mode register
   localparam int SYS_GIE_BIT = 0; // global interrupt enable
   localparam int SYS_FEN_BIT = 1; // fast handling enable
   localparam int SYS_LVL_LSB = 2; // level select, three bits upward from here
   localparam int SYS_LVL_MSB = 4;
   // position of the fast interrupt status bit inside the condition word
   localparam int FAST_FLAG_BIT = 1;
   localparam logic [7:0] FAST_FLAG_MASK = 8'h02;
   // entry lengths in core clock cycles
   localparam logic [4:0] FAST_ENTRY_CYC = 5'h06;
   localparam logic [4:0] VEC_ENTRY_CYC = 5'h10;
   // values after reset
   localparam logic [15:0] SSP_RST = 16'h0000;
   localparam logic [7:0] SHADOW_RST = 8'h00;
   localparam logic [4:0] CNT_RST = 5'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // entry sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, // waiting for a grant or a return
      ST_FAST = 2'b01, // short swap entry in progress
      ST_VEC = 2'b10 // stacked vectored entry in progress
   } fics_state_t;
endpackage

// ### hdl/fics_top.sv
// fast interrupt context swap unit between interrupt priority logic and sequencer
// assumes grant, return and core state inputs are synchronous to i_clk
//
// What this block does
// - three-bit field selects the fast level
// - the fast enable bit switches it; the global enable also gates it
// - fast entry swaps pointer and program counter
// - fast entry copies condition word to shadow
// - fast entry sets fast status bit
// - return with status set swaps back
// - fast return restores condition word from shadow
// - fast return clears fast status bit
// - works with either pending clear type
// - global enable gates fast interrupts too
// - pointer is two byte registers, high/low
// - any of eight levels is selectable
// - fast entry six cycles, vectored sixteen
`timescale 1ns/1ps
module fics_top (
   input wire logic i_clk, // core clock, 200 mhz
   input wire logic i_rst, // async reset, active high
   input wire logic [7:0] i_system_mode_register, // current system mode register
   input wire logic i_reg_wr, // one-cycle special register write strobe
   input wire logic [7:0] i_reg_addr, // special register address
   input wire logic [7:0] i_reg_wdata, // special register write data
   input wire logic i_irq_grant, // one-cycle grant from priority logic
   input wire logic [2:0] i_irq_level, // level of the granted interrupt
   input wire logic i_return_from_service, // one-cycle return decode
   input wire logic [15:0] i_program_counter, // current program counter
   input wire logic [7:0] i_flags, // current condition word
   output logic o_irq_ack, // grant accepted this cycle
   output logic o_fast_entry, // accepted grant uses the swap path
   output logic o_vec_entry, // accepted grant uses stacking and vector fetch
   output logic o_entry_done, // last cycle of the entry sequence
   output logic o_ret_fast, // return handled here, no stack pop
   output logic o_ret_stacked, // return must pop the stack
   output logic o_pc_load, // load o_pc_value into the program counter
   output logic [15:0] o_pc_value, // new program counter
   output logic o_flags_load, // load o_flags_value into the condition word
   output logic [7:0] o_flags_value, // new condition word
   output logic [15:0] o_service_start_pointer // pointer register pair contents
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   fics_pkg::fics_state_t state_ff; // entry sequencer state
   logic [4:0] cnt_ff; // cycle index within the entry
   logic [15:0] ssp_ff; // service start pointer pair
   logic [7:0] shadow_cond_ff; // unmapped shadow condition register
   logic pc_load_ff; // program counter load pulse
   logic [15:0] pc_value_ff; // program counter value
   logic flags_load_ff; // condition word load pulse
   logic [7:0] flags_value_ff; // condition word value
   logic gie; // global interrupt enable
   logic fen; // fast handling enable
   logic [2:0] fast_lvl; // selected fast level
   logic idle; // sequencer free
   logic take; // grant accepted
   logic is_fast; // accepted grant matches fast level
   logic fast_take; // fast entry starts
   logic ret_fast; // fast return starts
   logic [4:0] entry_last; // last cycle index of the current entry

   ////////////////////////////////////////////////////////////////////////////////
   // decode of system mode bits and the grant
   assign gie = i_system_mode_register[fics_pkg::SYS_GIE_BIT];
   // this bit turns fast handling on or off; the global enable still gates every fast entry
   assign fen = i_system_mode_register[fics_pkg::SYS_FEN_BIT];
   // all eight levels compare against the three-bit field
   assign fast_lvl = i_system_mode_register[fics_pkg::SYS_LVL_MSB:fics_pkg::SYS_LVL_LSB];
   assign idle = (state_ff == fics_pkg::ST_IDLE);
   // grants are ignored while disabled; the priority logic keeps them pending
   assign take = i_irq_grant && gie && idle;
   // the pending bit type is not looked at, so both kinds take the same path
   assign is_fast = fen && (i_irq_level == fast_lvl);
   assign fast_take = take && is_fast;
   // the status bit is read from the live condition word, so software may clear it
   assign ret_fast = i_return_from_service && idle && i_flags[fics_pkg::FAST_FLAG_BIT];
   assign o_irq_ack = take;
   assign o_fast_entry = fast_take;
   assign o_vec_entry = take && !is_fast;
   assign o_ret_fast = ret_fast;
   assign o_ret_stacked = i_return_from_service && idle && !i_flags[fics_pkg::FAST_FLAG_BIT];
   // entry length depends on which path was taken
   assign entry_last = (state_ff == fics_pkg::ST_FAST) ? (fics_pkg::FAST_ENTRY_CYC - 5'h01)
                                                      : (fics_pkg::VEC_ENTRY_CYC - 5'h01);
   assign o_entry_done = !idle && (cnt_ff == entry_last);
   assign o_pc_load = pc_load_ff;
   assign o_pc_value = pc_value_ff;
   assign o_flags_load = flags_load_ff;
   assign o_flags_value = flags_value_ff;
   assign o_service_start_pointer = ssp_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // entry sequencer: counts the cycles of the chosen entry path
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= fics_pkg::ST_IDLE;
         cnt_ff <= fics_pkg::CNT_RST;
      end else begin
         unique case (state_ff)
            fics_pkg::ST_IDLE: begin
               // the grant cycle is cycle zero of the entry
               if (take) begin
                  state_ff <= is_fast ? fics_pkg::ST_FAST : fics_pkg::ST_VEC;
                  cnt_ff <= 5'h01;
               end
            end
            fics_pkg::ST_FAST, fics_pkg::ST_VEC: begin
               if (cnt_ff == entry_last) begin
                  state_ff <= fics_pkg::ST_IDLE;
                  cnt_ff <= fics_pkg::CNT_RST;
               end else begin
                  cnt_ff <= cnt_ff + 5'h01;
               end
            end
            default: begin
               // illegal code, recover to idle
               state_ff <= fics_pkg::ST_IDLE;
               cnt_ff <= fics_pkg::CNT_RST;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // service start pointer pair; a swap beats a software write in the same cycle
   // because losing the interrupted address would be unrecoverable
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ssp_ff <= fics_pkg::SSP_RST;
      end else if (fast_take || ret_fast) begin
         ssp_ff <= i_program_counter;
      end else if (i_reg_wr && (i_reg_addr == fics_pkg::SSP_HI_ADDR)) begin
         ssp_ff[15:8] <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == fics_pkg::SSP_LO_ADDR)) begin
         ssp_ff[7:0] <= i_reg_wdata;
      end
   end
   // note: after a fast return the pair holds the address past the return,
   // so software reloads it before the next fast interrupt

   ////////////////////////////////////////////////////////////////////////////////
   // program counter hand-back, one cycle after entry or return
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pc_load_ff <= 1'b0;
         pc_value_ff <= fics_pkg::SSP_RST;
      end else begin
         pc_load_ff <= fast_take || ret_fast;
         if (fast_take || ret_fast) begin
            pc_value_ff <= ssp_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shadow condition register, written only on fast entry
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shadow_cond_ff <= fics_pkg::SHADOW_RST;
      end else if (fast_take) begin
         shadow_cond_ff <= i_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // condition word updates for fast entry and fast return
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flags_load_ff <= 1'b0;
         flags_value_ff <= fics_pkg::SHADOW_RST;
      end else begin
         flags_load_ff <= fast_take || ret_fast;
         if (fast_take) begin
            flags_value_ff <= i_flags | fics_pkg::FAST_FLAG_MASK;
         end else if (ret_fast) begin
            // restore and drop the status bit in one write
            flags_value_ff <= shadow_cond_ff & ~fics_pkg::FAST_FLAG_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   fast_pc_swap_a: assert property (fast_take |=> o_pc_load && o_pc_value == $past(ssp_ff))
      else $error("fast entry did not load pointer into pc");
   fast_ssp_swap_a: assert property (fast_take |=> ssp_ff == $past(i_program_counter))
      else $error("fast entry did not save pc into pointer");
   shadow_copy_a: assert property (fast_take |=> shadow_cond_ff == $past(i_flags))
      else $error("shadow not loaded on fast entry");
   status_set_a: assert property (fast_take |=> o_flags_load && o_flags_value[fics_pkg::FAST_FLAG_BIT])
      else $error("status bit not set on fast entry");
   ret_swap_back_a: assert property (ret_fast |=> o_pc_value == $past(ssp_ff) && ssp_ff == $past(i_program_counter))
      else $error("fast return did not swap back");
   ret_restore_a: assert property (ret_fast |=> o_flags_load && (o_flags_value | fics_pkg::FAST_FLAG_MASK) == ($past(shadow_cond_ff) | fics_pkg::FAST_FLAG_MASK))
      else $error("condition word not restored");
   ret_status_clear_a: assert property (ret_fast |=> !o_flags_value[fics_pkg::FAST_FLAG_BIT])
      else $error("status bit left set after fast return");
   gie_gate_a: assert property (!gie && idle |=> idle)
      else $error("entry started while globally disabled");
   level_match_a: assert property (o_fast_entry |-> fen && i_irq_level == fast_lvl)
      else $error("fast entry for unselected level");
   fen_off_vec_a: assert property (take && !fen |-> o_vec_entry)
      else $error("fast path used while disabled");
   fast_len_a: assert property (o_fast_entry |=> !o_entry_done [*4] ##1 o_entry_done)
      else $error("fast entry length wrong");
   vec_len_a: assert property (o_vec_entry |-> ##15 o_entry_done)
      else $error("vectored entry length wrong");

   fast_entry_c: cover property (fast_take ##[1:20] ret_fast);
   vec_entry_c: cover property (o_vec_entry);
   ret_stacked_c: cover property (o_ret_stacked);
   swap_beats_write_c: cover property (fast_take && i_reg_wr);
endmodule // fics_top

// ### verif/fics_seq_model.sv
// sequencer model: holds the program counter and condition word of the core
// assumes loads from the swap unit arrive as one-cycle pulses on i_clk
`timescale 1ns/1ps
module fics_seq_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_set, // bench preloads core state, as code running would
   input wire logic [15:0] i_pc_set,
   input wire logic [7:0] i_flags_set,
   input wire logic i_pc_load,
   input wire logic [15:0] i_pc_value,
   input wire logic i_flags_load,
   input wire logic [7:0] i_flags_value,
   output logic [15:0] o_program_counter,
   output logic [7:0] o_flags
);
   // loads land at the edge closing their cycle; a late load shows as a stale pc
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_program_counter <= 16'h0000;
         o_flags <= 8'h00;
      end else if (i_set) begin
         o_program_counter <= i_pc_set;
         o_flags <= i_flags_set;
      end else begin
         if (i_pc_load) o_program_counter <= i_pc_value;
         if (i_flags_load) o_flags <= i_flags_value;
      end
   end
endmodule // fics_seq_model

// ### verif/fast_interrupt_context_swap_tb.sv
// self-checking bench for the fast interrupt context swap unit
// assumes the sequencer model applies pc and flag loads; inputs move on falling edges
`timescale 1ns/1ps
module fast_interrupt_context_swap_tb;
   logic clk = 1'b0;
   logic rst, wr, grant, ret, set;
   logic [7:0] mode, addr, wdata, fl_set;
   logic [2:0] lvl;
   logic [15:0] pc_set;
   logic ack, fast, vec, done, rfast, rstk, pcl, fll;
   logic [15:0] pcv, ptr, pc;
   logic [7:0] flv, flags;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   fics_top i_fics_top (.i_clk(clk), .i_rst(rst), .i_system_mode_register(mode), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_irq_grant(grant), .i_irq_level(lvl),
      .i_return_from_service(ret), .i_program_counter(pc), .i_flags(flags), .o_irq_ack(ack),
      .o_fast_entry(fast), .o_vec_entry(vec), .o_entry_done(done), .o_ret_fast(rfast),
      .o_ret_stacked(rstk), .o_pc_load(pcl), .o_pc_value(pcv), .o_flags_load(fll),
      .o_flags_value(flv), .o_service_start_pointer(ptr));
   fics_seq_model i_fics_seq_model (.i_clk(clk), .i_rst(rst), .i_set(set), .i_pc_set(pc_set),
      .i_flags_set(fl_set), .i_pc_load(pcl), .i_pc_value(pcv), .i_flags_load(fll),
      .i_flags_value(flv), .o_program_counter(pc), .o_flags(flags));
   ////////////////////////////////////////////////////////////////////////////////
   // one compare, mismatch reported at once
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one strobe cycle, then an idle edge so back-to-back writes never
   // drop and raise the strobe in one time step
   task automatic wr_ptr(input logic [7:0] a, input logic [7:0] d);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic preset(input logic [15:0] p, input logic [7:0] f);
      set = 1'b1;
      pc_set = p;
      fl_set = f;
      @(negedge clk);
      set = 1'b0;
   endtask
   // one grant pulse, then count cycles up to the last entry cycle
   task automatic entry(input logic [2:0] l, input logic f, input logic [4:0] len);
      int n;
      grant = 1'b1;
      lvl = l;
      #1;
      chk(ack, 1'b1);
      chk(fast, f);
      chk(vec, !f);
      @(negedge clk);
      grant = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(n + 1, len);
      @(negedge clk);
   endtask
   task automatic rtn(input logic f);
      ret = 1'b1;
      #1;
      chk(rfast, f);
      chk(rstk, !f);
      @(negedge clk);
      ret = 1'b0;
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // fast entry and return on one level; pointer reloaded each time
   task automatic sc_fast(input logic [2:0] l);
      wr_ptr(fics_pkg::SSP_HI_ADDR, 8'h12);
      wr_ptr(fics_pkg::SSP_LO_ADDR, {5'h00, l});
      preset(16'habcd, 8'h80);
      mode = {3'b000, l, 2'b11};
      entry(l, 1'b1, fics_pkg::FAST_ENTRY_CYC);
      chk(pc, {8'h12, 5'h00, l});
      chk(ptr, 16'habcd);
      chk(flags, 8'h80 | fics_pkg::FAST_FLAG_MASK);
      preset(16'h5678, 8'h83); // routine ran on and touched a flag
      rtn(1'b1);
      chk(pc, 16'habcd);
      chk(ptr, 16'h5678);
      chk(flags, 8'h80);
   endtask
   // mismatched level, then fast off: both take the stacked path
   task automatic sc_vec();
      preset(16'h4321, 8'h40);
      mode = 8'h1f;
      entry(3'h3, 1'b0, fics_pkg::VEC_ENTRY_CYC);
      mode = 8'h0d;
      entry(3'h3, 1'b0, fics_pkg::VEC_ENTRY_CYC);
      rtn(1'b0);
      chk(pc, 16'h4321);
   endtask
   // held grant is ignored while global enable is off, taken once it is on
   task automatic sc_gie();
      mode = 8'h0e;
      grant = 1'b1;
      lvl = 3'h3;
      repeat (4) begin
         #1;
         chk(ack, 1'b0);
         @(negedge clk);
      end
      mode = 8'h0f;
      entry(3'h3, 1'b1, fics_pkg::FAST_ENTRY_CYC);
      rtn(1'b1);
      chk(flags, 8'h40);
      wr_ptr(8'hdc, 8'hff);
      @(negedge clk);
      chk(ptr, 16'h5678);
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk;
   // hang guard, far above the fewer than two hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      {rst, wr, grant, ret, set} = 5'h10;
      {mode, addr, wdata, fl_set, lvl, pc_set} = 51'h0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      for (int l = 0; l < 8; l++) sc_fast(l[2:0]);
      sc_vec();
      sc_gie();
      tally_and_finish();
   end
endmodule // fast_interrupt_context_swap_tb
